/* File: shared/rab_cfg.svh */
`ifndef RAB_CFG_SVH
`define RAB_CFG_SVH
// ==========================================================
// Address map, top of space, field lengths
`define RAB_ADDR_TOP 11'h6ff
`define RAB_A_BANK 11'h000
`define RAB_A_EDGE 11'h010
`define RAB_A_IE 11'h011
`define RAB_A_CFGSR 11'h040
`define RAB_A_LIVE 11'h041
`define RAB_A_GLAT 11'h043
`define RAB_A_MFREQ 11'h065
`define RAB_A_PHOFF 11'h070
`define RAB_A_MPHASE 11'h074
`define RAB_A_FOFF 11'h078
`define RAB_LEN32 11'h004
`define RAB_LEN40 11'h005
// ==========================================================
// Strap codes, reset values, timing
`define RAB_IF_EXT 2'h3
`define RAB_AC_DIRECT 2'h0
`define RAB_EDGE_RST 4'h5
`define RAB_SYNC_CYC 2'h2
`endif

/* File: shared/rab_pkg.sv */
`default_nettype none
package rab_pkg;
    typedef enum logic [2:0] {
        FLD_NONE = 3'b000,
        FLD_FOFF = 3'b001,
        FLD_PHOFF = 3'b010,
        FLD_MFREQ = 3'b011,
        FLD_MPHASE = 3'b100
    } rab_field_t;

    typedef enum logic [1:0] {
        BT_SYNC = 2'b00,
        BT_DECIDE = 2'b01,
        BT_LOAD = 2'b10,
        BT_DONE = 2'b11
    } rab_boot_t;

    typedef struct packed {
        rab_field_t fld;
        logic [2:0] idx;
        logic last;
    } rab_dec_t;

    typedef struct packed {
        logic [1:0] if_s1;
        logic [1:0] if_s2;
        logic [1:0] ac_s1;
        logic [1:0] ac_s2;
        logic test_s1;
        logic test_s2;
        logic [1:0] cnt;
        rab_boot_t bt;
        logic [1:0] if_cap;
        logic [1:0] ac_cap;
        logic test_cap;
        logic bank;
        logic [3:0] edge_cfg;
        logic [2:0] irq_en;
        logic [2:0] lat;
        logic [1:0] src_prev;
        logic done_prev;
        logic boot_start;
        logic boot_ext;
        logic [1:0] boot_slot;
        logic [39:0] foff;
        logic [31:0] phoff;
        logic [31:0] wr_xfer;
        logic [39:0] rd_xfer;
        logic [7:0] rdata;
        logic rvalid;
        logic [10:0] ee_addr;
        logic [7:0] ee_wdata;
        logic ee_wr;
        logic ee_rd;
        logic irq;
        logic miso_on;
    } rab_state_t;
endpackage
`default_nettype wire

/* File: design/rab_regbank.sv */
// Summary of operation
// RL1: Interface straps 11 at reset load configuration from external SPI EEPROM slot.
// RL2: External EEPROM holds configurations one to three, picked by autoconfig pins.
// RL3: Internal EEPROM holds configurations zero to three, picked by autoconfig pins.
// RL4: Test strap high with autoconfig 00 at reset release enters direct write mode.
// RL5: Direct write mode maps EEPROM writable; configuration registers become inaccessible.
// RL6: Direct write mode ends only when test strap is low at reset release.
// RL7: In direct write mode MISO is driven continuously.
// RL8: Host sets GPIO0 as reset by writing 0x1F and 0x04 to two registers; the block has no GPIO and decodes neither register.
// RL9: Register space spans 000h to 6FFh, eight bits per register.
// RL10: Host writes zero to reserved bits and unlisted addresses.
// RL11: Writes to read-only fields are ignored.
// RL12: Real-time status bits are read-only and show live source state.
// RL13: Latched bits set on chosen edge, clear on written 1, ignore 0.
// RL14: A set latched bit with its enable set raises the interrupt request.
// RL15: Reset returns every configuration field to its default.
// RL16: Multibyte writes stage in transfer register; highest byte write commits all.
// RL17: Reads during a pending multibyte write return the committed value.
// RL18: Reading lowest byte snapshots field; later bytes come from the snapshot.
// RL19: Writes during a multibyte read overwrite bytes in the read snapshot.
// RL20: One write and one read transfer register serve all multibyte fields.
// RL21: Fields: 40-bit frequency offset, 32-bit phase offset, two 32-bit measurements.
// RL22: Bank bit 0 maps registers from 0x1 up, 1 maps EEPROM; bank at 0x0.
// RL23: Bank bit resets to 0.
`timescale 1ns/1ps
`default_nettype none
`include "rab_cfg.svh"

module rab_regbank
    import rab_pkg::*;
#(
    parameter bit INTERNAL_EE = 1'b1
)(
    input wire logic clk, // 40 MHz master clock
    input wire logic external_reset_n, // External reset, async, active low
    input wire logic [1:0] interface_select_pins, // Strap pins, async
    input wire logic [1:0] autoconfig_select_pins, // Strap pins, async
    input wire logic test_strap, // Strap pin, async
    input wire logic [10:0] host_addr, // Register byte address
    input wire logic host_wr, // Write strobe, one cycle
    input wire logic host_rd, // Read strobe, one cycle
    input wire logic [7:0] host_wdata, // Write data
    output logic [7:0] host_rdata, // Read data
    output logic host_rvalid, // Read data valid pulse
    input wire logic [1:0] live_src, // Status sources, same clock
    input wire logic boot_load_done, // Loader finished, level
    input wire logic [31:0] meas_freq_in, // Measured frequency
    input wire logic [31:0] meas_phase_in, // Measured phase
    input wire logic [7:0] ee_rdata, // EEPROM read data
    output logic [10:0] ee_addr, // EEPROM address
    output logic [7:0] ee_wdata, // EEPROM write data
    output logic ee_wr, // EEPROM write pulse
    output logic ee_rd, // EEPROM read pulse
    output logic miso_drive_always, // Keep MISO driven
    output logic boot_load_start, // Start autoconfig load pulse
    output logic boot_from_ext, // Load from external EEPROM
    output logic [1:0] boot_slot, // Configuration slot
    output logic [39:0] freq_offset_word, // Committed freq offset
    output logic [31:0] phase_offset_word, // Committed phase offset
    output logic irq_request // Interrupt request, level
);
    // ======================================================
    // Helpers
    function automatic logic in_rng(input logic [10:0] a, b, len);
        in_rng = (a >= b) && (a < 11'(b + len));
    endfunction
    function automatic rab_dec_t rab_decode(input logic [10:0] a);
        rab_dec_t d;
        d = '{fld: FLD_NONE, idx: 3'h0, last: 1'b0};
        if (in_rng(a, `RAB_A_FOFF, `RAB_LEN40))
        begin
            d.fld = FLD_FOFF;
            d.idx = 3'(a - `RAB_A_FOFF);
            d.last = (a == 11'(`RAB_A_FOFF + `RAB_LEN40 - 11'h001));
        end
        else if (in_rng(a, `RAB_A_PHOFF, `RAB_LEN32))
        begin
            d.fld = FLD_PHOFF;
            d.idx = 3'(a - `RAB_A_PHOFF);
            d.last = (a == 11'(`RAB_A_PHOFF + `RAB_LEN32 - 11'h001));
        end
        else if (in_rng(a, `RAB_A_MFREQ, `RAB_LEN32))
        begin
            d.fld = FLD_MFREQ;
            d.idx = 3'(a - `RAB_A_MFREQ);
        end
        else if (in_rng(a, `RAB_A_MPHASE, `RAB_LEN32))
        begin
            d.fld = FLD_MPHASE;
            d.idx = 3'(a - `RAB_A_MPHASE);
        end
        rab_decode = d;
    endfunction
    function automatic logic [7:0] pick(input logic [39:0] w, input logic [2:0] i);
        pick = w[{i, 3'h0} +: 8];
    endfunction
    rab_state_t st_ff;
    rab_state_t n;
    rab_dec_t dec;
    logic dmode_ff;
    logic nxt_dmode;
    logic in_space, ee_sel, reg_sel;
    logic [39:0] fword;
    logic [1:0] rise, fall;
    // ======================================================
    // Direct write mode survives reset on purpose
    // Cleared only by a low test strap at release; no async reset here.
    always_comb
    begin
        nxt_dmode = dmode_ff;
        if (st_ff.bt == BT_DECIDE)
        begin
            if (!st_ff.test_s2)
                nxt_dmode = 1'b0; // [RL6]
            else if (INTERNAL_EE && st_ff.ac_s2 == `RAB_AC_DIRECT)
                nxt_dmode = 1'b1; // [RL4]
        end
    end
    always_ff @(posedge clk)
    begin
        dmode_ff <= nxt_dmode;
    end

    // ======================================================
    // Next-state logic
    always_comb
    begin
        n = st_ff;
        dec = rab_decode(host_addr);
        fword = 40'h0;
        n.boot_start = 1'b0;
        n.rvalid = 1'b0;
        n.ee_wr = 1'b0;
        n.ee_rd = 1'b0;
        // Two-flop strap synchronisers
        n.if_s1 = interface_select_pins;
        n.if_s2 = st_ff.if_s1;
        n.ac_s1 = autoconfig_select_pins;
        n.ac_s2 = st_ff.ac_s1;
        n.test_s1 = test_strap;
        n.test_s2 = st_ff.test_s1;
        // Boot sequencer: straps taken once synchronisers settle
        case (st_ff.bt)
            BT_SYNC:
            begin
                n.cnt = 2'(st_ff.cnt + 2'h1);
                if (st_ff.cnt == `RAB_SYNC_CYC)
                    n.bt = BT_DECIDE;
            end
            BT_DECIDE:
            begin
                n.if_cap = st_ff.if_s2;
                n.ac_cap = st_ff.ac_s2;
                n.test_cap = st_ff.test_s2;
                n.boot_slot = st_ff.ac_s2;
                n.bt = BT_DONE;
                if (nxt_dmode)
                    n.bt = BT_DONE;
                else if (st_ff.if_s2 == `RAB_IF_EXT && st_ff.ac_s2 != 2'h0)
                begin
                    n.boot_ext = 1'b1; // [RL1] [RL2]
                    n.boot_start = 1'b1;
                    n.bt = BT_LOAD;
                end
                else if (INTERNAL_EE && st_ff.if_s2 != `RAB_IF_EXT)
                begin
                    n.boot_start = 1'b1; // [RL3]
                    n.bt = BT_LOAD;
                end
            end
            BT_LOAD:
                if (boot_load_done)
                    n.bt = BT_DONE;
            BT_DONE: n.bt = BT_DONE;
            default: n.bt = BT_SYNC;
        endcase
        // Latched status: edge detect, done bit, write-1-to-clear; set wins
        n.src_prev = live_src;
        n.done_prev = (st_ff.bt == BT_DONE);
        rise = live_src & ~st_ff.src_prev;
        fall = ~live_src & st_ff.src_prev;
        if (host_wr && !dmode_ff && !(INTERNAL_EE && st_ff.bank) && host_addr == `RAB_A_GLAT)
            n.lat = st_ff.lat & ~{host_wdata[7], host_wdata[1:0]}; // [RL13]
        n.lat[0] = n.lat[0] | (rise[0] & st_ff.edge_cfg[0])
                 | (fall[0] & st_ff.edge_cfg[1]); // [RL13]
        n.lat[1] = n.lat[1] | (rise[1] & st_ff.edge_cfg[2])
                 | (fall[1] & st_ff.edge_cfg[3]);
        n.lat[2] = n.lat[2] | ((st_ff.bt == BT_DONE) & ~st_ff.done_prev);
        n.irq = |(st_ff.lat & st_ff.irq_en); // [RL14]
        n.miso_on = dmode_ff; // [RL7]
        // Address steering: bank 0x0 always present
        in_space = (host_addr <= `RAB_ADDR_TOP); // [RL9]
        ee_sel = INTERNAL_EE && in_space && host_addr != `RAB_A_BANK
               && (dmode_ff || st_ff.bank); // [RL22] [RL5]
        reg_sel = in_space && !ee_sel && !dmode_ff; // [RL5]
        case (dec.fld)
            FLD_FOFF: fword = st_ff.foff;
            FLD_PHOFF: fword = {8'h0, st_ff.phoff};
            FLD_MFREQ: fword = {8'h0, meas_freq_in};
            FLD_MPHASE: fword = {8'h0, meas_phase_in};
            default: fword = 40'h0;
        endcase
        if (host_wr)
        begin
            if (host_addr == `RAB_A_BANK)
                n.bank = host_wdata[0]; // [RL22]
            else if (ee_sel)
            begin
                n.ee_addr = host_addr;
                n.ee_wdata = host_wdata;
                n.ee_wr = 1'b1; // [RL5]
            end
            else if (reg_sel)
            begin
                // Read-only addresses fall through untouched
                case (host_addr)
                    `RAB_A_EDGE: n.edge_cfg = host_wdata[3:0];
                    `RAB_A_IE: n.irq_en = {host_wdata[7], host_wdata[1:0]};
                    default: n.edge_cfg = n.edge_cfg; // [RL11]
                endcase
                if (dec.fld == FLD_FOFF || dec.fld == FLD_PHOFF)
                begin
                    n.rd_xfer[{dec.idx, 3'h0} +: 8] = host_wdata; // [RL19]
                    if (!dec.last)
                        n.wr_xfer[{dec.idx[1:0], 3'h0} +: 8] = host_wdata; // [RL16] [RL20]
                    else if (dec.fld == FLD_FOFF)
                        n.foff = {host_wdata, st_ff.wr_xfer}; // [RL16] [RL21]
                    else
                        n.phoff = {host_wdata, st_ff.wr_xfer[23:0]}; // [RL16] [RL21]
                end
            end
        end
        else if (host_rd)
        begin
            n.rvalid = !ee_sel;
            n.rdata = 8'h0;
            if (ee_sel)
            begin
                n.ee_addr = host_addr;
                n.ee_rd = 1'b1;
            end
            else if (host_addr == `RAB_A_BANK)
                n.rdata = {7'h0, st_ff.bank};
            else if (reg_sel && dec.fld != FLD_NONE)
            begin
                if (dec.idx == 3'h0)
                begin
                    n.rd_xfer = fword; // [RL18] [RL17]
                    n.rdata = pick(fword, 3'h0);
                end
                else
                    n.rdata = pick(st_ff.rd_xfer, dec.idx); // [RL18]
            end
            else if (reg_sel)
            begin
                case (host_addr)
                    `RAB_A_EDGE: n.rdata = {4'h0, st_ff.edge_cfg};
                    `RAB_A_IE: n.rdata = {st_ff.irq_en[2], 5'h0, st_ff.irq_en[1:0]};
                    `RAB_A_CFGSR: n.rdata = {st_ff.test_cap, 3'h0, st_ff.if_cap,
                                             st_ff.ac_cap};
                    `RAB_A_LIVE: n.rdata = {6'h0, live_src}; // [RL12]
                    `RAB_A_GLAT: n.rdata = {st_ff.lat[2], 5'h0, st_ff.lat[1:0]};
                    default: n.rdata = 8'h0;
                endcase
            end
        end
        // EEPROM answers in the cycle its read pulse is out
        if (st_ff.ee_rd)
        begin
            n.rdata = ee_rdata;
            n.rvalid = 1'b1;
        end
    end
    // ======================================================
    // State register; every field to its default on reset
    always_ff @(posedge clk or negedge external_reset_n)
    begin
        if (!external_reset_n)
        begin
            st_ff <= '0; // [RL15] [RL23]
            st_ff.bt <= BT_SYNC;
            st_ff.edge_cfg <= `RAB_EDGE_RST;
        end
        else
            st_ff <= n;
    end
    // Outputs straight from flops
    assign host_rdata = st_ff.rdata;
    assign host_rvalid = st_ff.rvalid;
    assign ee_addr = st_ff.ee_addr;
    assign ee_wdata = st_ff.ee_wdata;
    assign ee_wr = st_ff.ee_wr;
    assign ee_rd = st_ff.ee_rd;
    assign miso_drive_always = st_ff.miso_on;
    assign boot_load_start = st_ff.boot_start;
    assign boot_from_ext = st_ff.boot_ext;
    assign boot_slot = st_ff.boot_slot;
    assign freq_offset_word = st_ff.foff;
    assign phase_offset_word = st_ff.phoff;
    assign irq_request = st_ff.irq;

    // ======================================================
    // Assertions
    property p_direct_enter;
        @(posedge clk) disable iff (!external_reset_n)
        (st_ff.bt == BT_DECIDE && st_ff.test_s2 && st_ff.ac_s2 == 2'h0 && INTERNAL_EE)
        |=> dmode_ff ##1 miso_drive_always;
    endproperty
    a_direct_enter: assert property (p_direct_enter) else $error("direct mode not entered"); // [RL4]
    property p_direct_exit;
        @(posedge clk) disable iff (!external_reset_n)
        (st_ff.bt == BT_DECIDE && !st_ff.test_s2) |=> !dmode_ff;
    endproperty
    a_direct_exit: assert property (p_direct_exit) else $error("direct mode not left"); // [RL6]
    property p_miso;
        @(posedge clk) disable iff (!external_reset_n)
        $rose(dmode_ff) |=> miso_drive_always [*2];
    endproperty
    a_miso: assert property (p_miso) else $error("MISO not held driven"); // [RL7]
    property p_ext_boot;
        @(posedge clk) disable iff (!external_reset_n)
        (st_ff.bt == BT_DECIDE && !nxt_dmode && st_ff.if_s2 == 2'h3 && st_ff.ac_s2 != 2'h0)
        |=> boot_load_start && boot_from_ext && boot_slot == $past(st_ff.ac_s2);
    endproperty
    a_ext_boot: assert property (p_ext_boot) else $error("external load not started"); // [RL1]
    property p_w0_keeps;
        @(posedge clk) disable iff (!external_reset_n)
        (host_wr && host_addr == `RAB_A_GLAT && !host_wdata[0] && st_ff.lat[0])
        |=> st_ff.lat[0];
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) else $error("latched bit lost on 0 write"); // [RL13]
    property p_irq;
        @(posedge clk) disable iff (!external_reset_n)
        (st_ff.lat[0] && st_ff.irq_en[0]) |=> irq_request;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised"); // [RL14]
    property p_stage;
        @(posedge clk) disable iff (!external_reset_n)
        (host_wr && reg_sel && dec.fld == FLD_FOFF && !dec.last)
        |=> $stable(freq_offset_word);
    endproperty
    a_stage: assert property (p_stage) else $error("field changed before last byte"); // [RL16]
    property p_snap;
        @(posedge clk) disable iff (!external_reset_n)
        (!host_wr && host_rd && reg_sel && dec.fld != FLD_NONE && dec.idx != 3'h0)
        |=> host_rvalid && host_rdata == pick($past(st_ff.rd_xfer), $past(dec.idx));
    endproperty
    a_snap: assert property (p_snap) else $error("read not from snapshot"); // [RL18]
    property p_ro;
        @(posedge clk) disable iff (!external_reset_n)
        (host_wr && host_addr == `RAB_A_CFGSR) |=> $stable(st_ff.ac_cap);
    endproperty
    a_ro: assert property (p_ro) else $error("read-only field changed"); // [RL11]
    property p_bank;
        @(posedge clk) disable iff (!external_reset_n)
        (host_wr && INTERNAL_EE && st_ff.bank && host_addr != 11'h000
         && host_addr <= 11'h6ff) |=> ee_wr;
    endproperty
    a_bank: assert property (p_bank) else $error("EEPROM bank not reached"); // [RL22]
    c_direct: cover property (@(posedge clk) disable iff (!external_reset_n) $rose(dmode_ff));
    c_commit: cover property (@(posedge clk) disable iff (!external_reset_n)
        host_wr && dec.fld == FLD_FOFF && dec.last);
    c_irq: cover property (@(posedge clk) disable iff (!external_reset_n) $rose(irq_request));
    c_boot: cover property (@(posedge clk) disable iff (!external_reset_n) boot_load_start);
endmodule
`default_nettype wire

/* File: tb/rab_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// EEPROM array and configuration loader beside the block
module rab_far_side #(
    parameter int DONE_DELAY = 3 // Load length in cycles
)(
    input wire logic clk, // Master clock
    input wire logic external_reset_n, // Reset, active low
    input wire logic [10:0] ee_addr, // EEPROM address
    input wire logic [7:0] ee_wdata, // EEPROM write data
    input wire logic ee_wr, // Write pulse
    input wire logic ee_rd, // Read pulse
    output logic [7:0] ee_rdata, // Read data
    input wire logic boot_load_start, // Load request pulse
    output logic boot_load_done // Load finished, level
);
    logic [7:0] mem [0:2047];
    logic [7:0] last_q;
    int cnt;
    // Known fill pattern, so a read never passes by luck
    initial
    begin
        last_q = 8'h00;
        for (int i = 0; i < 2048; i++)
            mem[i] = 8'(i) ^ 8'ha5;
    end
    // Data only in the read cycle; otherwise the inverse of the last byte
    assign ee_rdata = ee_rd ? mem[ee_addr] : ~last_q;
    // Array update and last-byte memory
    always_ff @(posedge clk)
    begin
        if (ee_wr)
            mem[ee_addr] <= ee_wdata;
        if (ee_rd)
            last_q <= mem[ee_addr];
    end
    // Loader answers a start after a fixed delay and holds done
    always_ff @(posedge clk or negedge external_reset_n)
    begin
        if (!external_reset_n)
        begin
            cnt <= 0;
            boot_load_done <= 1'b0;
        end
        else if (boot_load_start)
            cnt <= DONE_DELAY;
        else if (cnt == 1)
        begin
            cnt <= 0;
            boot_load_done <= 1'b1;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, external_reset_n, test_pin, host_wr, host_rd, host_rvalid, load_done, ee_wr, ee_rd;
    logic miso_on, load_start, from_ext, irq;
    logic [1:0] if_pins, ac_pins, live_src, slot;
    logic [10:0] host_addr, ee_addr;
    logic [7:0] host_wdata, host_rdata, ee_rdata, ee_wdata;
    logic [31:0] mfreq, mphase, phoff;
    logic [39:0] foff;
    int failures;
    int check_count;
    // ==========================================================
    // Block and its far side
    rab_regbank #(.INTERNAL_EE(1'b1)) rab_regbank_i (
        .clk(clk), .external_reset_n(external_reset_n), .interface_select_pins(if_pins),
        .autoconfig_select_pins(ac_pins), .test_strap(test_pin), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .live_src(live_src),
        .boot_load_done(load_done), .meas_freq_in(mfreq), .meas_phase_in(mphase),
        .ee_rdata(ee_rdata), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_wr(ee_wr),
        .ee_rd(ee_rd), .miso_drive_always(miso_on), .boot_load_start(load_start),
        .boot_from_ext(from_ext), .boot_slot(slot), .freq_offset_word(foff),
        .phase_offset_word(phoff), .irq_request(irq)
    );
    rab_far_side rab_far_side_i (
        .clk(clk), .external_reset_n(external_reset_n), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_wr(ee_wr),
        .ee_rd(ee_rd), .ee_rdata(ee_rdata), .boot_load_start(load_start),
        .boot_load_done(load_done)
    );
    // ==========================================================
    // Clock, 25 ns period
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ==========================================================
    // Access tasks; all driving happens at the falling edge
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(negedge clk);
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        @(negedge clk);
        host_wr = 1'b0;
    endtask
    // Read with a bounded wait: EEPROM reads answer a cycle later
    task automatic rdc(input logic [10:0] a, input logic [7:0] e);
        logic [7:0] got;
        got = 8'hxx;
        @(negedge clk);
        host_addr = a;
        host_rd = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk);
            host_rd = 1'b0;
            if (host_rvalid === 1'b1)
            begin
                got = host_rdata;
                break;
            end
        end
        chk(got, e);
    endtask
    // Straps must stay put after release, the synchroniser samples late
    task automatic do_reset(input logic [1:0] i, input logic [1:0] a, input logic t);
        @(negedge clk);
        external_reset_n = 1'b0;
        if_pins = i;
        ac_pins = a;
        test_pin = t;
        repeat (4) @(negedge clk);
        external_reset_n = 1'b1;
        repeat (16) @(negedge clk);
    endtask
    task automatic settle();
        repeat (4) @(negedge clk);
    endtask
    task automatic give_verdict();
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================================
    // Watchdog, far beyond the few hundred cycles the run needs
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict();
    end
    // ==========================================================
    // Test sequence
    initial
    begin
        external_reset_n = 1'b0;
        {if_pins, ac_pins, test_pin, host_wr, host_rd, live_src} = '0;
        host_addr = 11'h000;
        host_wdata = 8'h00;
        mfreq = 32'h89abcdef;
        mphase = 32'h01234567;
        failures = 0;
        check_count = 0;
        // Internal load from slot 2, defaults, read-only and unmapped places
        do_reset(2'h0, 2'h2, 1'b0);
        chk(from_ext, 1'b0);
        chk(slot, 2'h2);
        rdc(11'h043, 8'h80);
        rdc(11'h000, 8'h00);
        rdc(11'h010, 8'h05);
        wr(11'h040, 8'h8f);
        rdc(11'h040, 8'h02);
        rdc(11'h6ff, 8'h00);
        rdc(11'h700, 8'h00);
        wr(11'h043, 8'h80);
        rdc(11'h043, 8'h00);
        wr(11'h012, 8'h1f);
        wr(11'h00e, 8'h04);
        // Rising edge latches; zero writes ignored; enable gates the request
        @(negedge clk);
        live_src = 2'h1;
        settle();
        rdc(11'h041, 8'h01);
        rdc(11'h043, 8'h01);
        chk(irq, 1'b0);
        wr(11'h043, 8'h00);
        rdc(11'h043, 8'h01);
        wr(11'h011, 8'h01);
        settle();
        chk(irq, 1'b1);
        wr(11'h043, 8'h01);
        settle();
        chk(irq, 1'b0);
        // Falling only on source 0: a rise must no longer latch
        wr(11'h010, 8'h06);
        @(negedge clk);
        live_src = 2'h0;
        settle();
        rdc(11'h043, 8'h01);
        wr(11'h043, 8'h01);
        @(negedge clk);
        live_src = 2'h3;
        settle();
        rdc(11'h041, 8'h03);
        rdc(11'h043, 8'h02);
        // Staged write, committed only by the top byte
        for (int k = 0; k < 4; k++)
            wr(11'h078 + 11'(k), 8'h11 * 8'(k + 1));
        rdc(11'h078, 8'h00);
        chk(foff, 40'h0);
        wr(11'h07c, 8'h55);
        settle();
        chk(foff, 40'h5544332211);
        // Abandoned write, then a phase write through the shared stage
        for (int k = 0; k < 4; k++)
            wr(11'h078 + 11'(k), 8'haa);
        for (int k = 0; k < 4; k++)
            wr(11'h070 + 11'(k), 8'h10 + 8'(k));
        settle();
        chk(foff, 40'h5544332211);
        chk(phoff, 32'h13121110);
        // Snapshot of a measured word survives a source change
        rdc(11'h065, 8'hef);
        @(negedge clk);
        mfreq = 32'h0;
        wr(11'h066, 8'h77);
        rdc(11'h066, 8'hcd);
        rdc(11'h067, 8'hab);
        rdc(11'h068, 8'h89);
        rdc(11'h065, 8'h00);
        rdc(11'h074, 8'h67);
        rdc(11'h077, 8'h01);
        // A write during a read lands in the snapshot and the write stage, not the committed word
        rdc(11'h070, 8'h10);
        wr(11'h072, 8'h5a);
        rdc(11'h072, 8'h5a);
        rdc(11'h073, 8'h13);
        chk(phoff, 32'h13121110);
        // EEPROM bank and back
        wr(11'h000, 8'h01);
        rdc(11'h000, 8'h01);
        rdc(11'h020, 8'h85);
        wr(11'h010, 8'h3c);
        rdc(11'h010, 8'h3c);
        wr(11'h000, 8'h00);
        rdc(11'h010, 8'h06);
        // Direct write mode: entry, sticky while the test strap stays high
        do_reset(2'h0, 2'h0, 1'b1);
        chk(miso_on, 1'b1);
        rdc(11'h040, 8'he5);
        wr(11'h041, 8'h77);
        rdc(11'h041, 8'h77);
        do_reset(2'h0, 2'h1, 1'b1);
        chk(miso_on, 1'b1);
        do_reset(2'h0, 2'h2, 1'b0);
        chk(miso_on, 1'b0);
        rdc(11'h010, 8'h05);
        chk(foff, 40'h0);
        // External load picks slot 3
        do_reset(2'h3, 2'h3, 1'b0);
        chk(from_ext, 1'b1);
        chk(slot, 2'h3);
        give_verdict();
    end
endmodule
`default_nettype wire
